// ---- design/tmr8_counter_compare.sv ----
/*
 * Eight-bit timer with one compare channel: counter, compare value that is
 * double-buffered in the PWM modes, flags with interrupt requests and the compare output.
 * Assumes processor strobes are one cycle wide and synchronous to sys_clk,
 * and that the interrupt controller pulses an acknowledge when it services
 * a request. Pin direction and the pin mux are handled outside; the override select is made here.
 */
`timescale 1ns/1ps
module tmr8_counter_compare
    import tmr8_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Control fields
    input  wire tmr8_ctrl_s ctrl,
    input  wire logic       compareIrqEnable,
    input  wire logic       overflowIrqEnable,
    input  wire logic       crystalPinIn,
    // Processor access strobes
    input  wire logic       countWrite,
    input  wire logic [7:0] countWriteData,
    input  wire logic       compareWrite,
    input  wire logic [7:0] compareWriteData,
    input  wire logic       forceCompareStrobe,
    input  wire logic       compareFlagClear,
    input  wire logic       overflowFlagClear,
    // Interrupt service acknowledges
    input  wire logic       compareIrqAck,
    input  wire logic       overflowIrqAck,
    // Readback
    output logic [7:0]      countValue,
    output logic [7:0]      compareValue,
    output logic            compareFlag,
    output logic            overflowFlag,
    // Interrupt requests
    output logic            compareIrq,
    output logic            overflowIrq,
    // Waveform
    output logic            compareOutput,
    output logic            portOverride
);

    // One-hot count direction used by phase-correct mode.
    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } tmr8_dir_e;

    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic [7:0] cmpActive_r;
    logic [7:0] cmpBuffer_r;
    logic       blockMatch_r;
    logic       cmpFlag_r;
    logic       ovfFlag_r;
    logic       cmpIrq_r;
    logic       ovfIrq_r;
    logic       outState_r;
    logic       outState_nxt;
    logic       override_r;
    tmr8_dir_e  dir_r;
    tmr8_dir_e  dir_nxt;
    logic       timerTick;
    logic       match;
    logic       isBottom;
    logic       isMax;
    logic       pwmMode;
    logic       ovfEvent;
    logic       bufLoad;
    logic       liveMatch;
    logic [7:0] cmpView_r;

    // True for both PWM modes, where the compare value is double buffered.
    function automatic logic is_pwm(input logic [1:0] mode);
        is_pwm = (mode == WGM_PCPWM) || (mode == WGM_FASTPWM);
    endfunction

    // Output value that a compare action yields from the current value.
    function automatic logic apply_action(input logic [1:0] act,
                                          input logic       cur);
        case (act)
            ACT_TOGGLE: apply_action = ~cur;
            ACT_CLEAR:  apply_action = 1'b0;
            ACT_SET:    apply_action = 1'b1;
            default:    apply_action = cur;
        endcase
    endfunction

    // ********************************************************************
    // Tick source
    // ********************************************************************
    tmr8_tick_gen u_tick (
        .sys_clk          (sys_clk),
        .reset            (reset),
        .asyncClockSelect (ctrl.asyncSel),
        .crystalPinIn     (crystalPinIn),
        .clockSelectField (ctrl.clockSel),
        .timerTick        (timerTick)
    );

    // ********************************************************************
    // Comparator and extremes
    // ********************************************************************
    assign match    = (count_r == cmpActive_r);
    assign isBottom = (count_r == CNT_BOTTOM);
    assign isMax    = (count_r == CNT_MAX);
    assign pwmMode  = is_pwm(ctrl.waveMode);

    // A match right after a count write is swallowed.
    assign liveMatch = match && !blockMatch_r;

    // ********************************************************************
    // Counter next value
    // ********************************************************************
    // Top is the compare value in clear-on-match mode and 0xFF elsewhere.
    always_comb begin
        count_nxt = count_r;
        dir_nxt   = dir_r;
        ovfEvent  = 1'b0;
        case (ctrl.waveMode)
            WGM_NORMAL: begin
                count_nxt = count_r + 8'h01;
                ovfEvent  = isMax;
            end
            WGM_CTC: begin
                count_nxt = liveMatch ? CNT_BOTTOM : count_r + 8'h01;
                ovfEvent  = isMax;
            end
            WGM_FASTPWM: begin
                count_nxt = count_r + 8'h01;
                ovfEvent  = isMax;
            end
            WGM_PCPWM: begin
                // Direction flips on the tick at an extreme.
                if (isMax) begin
                    dir_nxt = DIR_DOWN;
                end else if (isBottom) begin
                    dir_nxt = DIR_UP;
                end
                count_nxt = (dir_nxt == DIR_UP) ? count_r + 8'h01
                                                : count_r - 8'h01;
                ovfEvent  = isBottom;
            end
            default: begin
                count_nxt = count_r;
            end
        endcase
    end

    // ********************************************************************
    // Counter register
    // ********************************************************************
    // The processor write is checked first so it wins over any tick.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_r <= CNT_RESET;
            dir_r   <= DIR_UP;
        end else if (countWrite) begin
            count_r <= countWriteData;
        end else if (timerTick) begin
            count_r <= count_nxt;
            dir_r   <= dir_nxt;
        end
    end

    // ********************************************************************
    // Match blocking after a count write
    // ********************************************************************
    // Held until the next tick consumes it, even while stopped.
    // Software can thus preload count and compare safely.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            blockMatch_r <= 1'b0;
        end else if (countWrite) begin
            blockMatch_r <= 1'b1;
        end else if (timerTick) begin
            blockMatch_r <= 1'b0;
        end
    end

    // ********************************************************************
    // Compare value and its buffer
    // ********************************************************************
    // Fast PWM reloads at max, phase-correct at top of its slope (max).
    assign bufLoad = timerTick && pwmMode && isMax;

    // In PWM a write reaches only the buffer, so a slope
    // never sees its compare value change halfway.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmpBuffer_r <= CMP_RESET;
            cmpActive_r <= CMP_RESET;
        end else begin
            if (compareWrite) begin
                cmpBuffer_r <= compareWriteData;
            end
            if (compareWrite && !pwmMode) begin
                cmpActive_r <= compareWriteData;
            end else if (bufLoad) begin
                cmpActive_r <= cmpBuffer_r;
            end
        end
    end

    // ********************************************************************
    // Compare readback register
    // ********************************************************************
    // A flop keeps the mode mux off the port; a mode change
    // shows a cycle late, a write shows at once.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmpView_r <= CMP_RESET;
        end else if (compareWrite) begin
            cmpView_r <= compareWriteData;
        end else begin
            cmpView_r <= pwmMode ? cmpBuffer_r : cmpActive_r;
        end
    end

    // ********************************************************************
    // Flags and interrupt requests
    // ********************************************************************
    // A hardware set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmpFlag_r <= 1'b0;
        end else if (timerTick && liveMatch) begin
            cmpFlag_r <= 1'b1;
        end else if (compareFlagClear || compareIrqAck) begin
            cmpFlag_r <= 1'b0;
        end
    end

    // Overflow alike; a count write suppresses its set.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ovfFlag_r <= 1'b0;
        end else if (timerTick && !countWrite && ovfEvent) begin
            ovfFlag_r <= 1'b1;
        end else if (overflowFlagClear || overflowIrqAck) begin
            ovfFlag_r <= 1'b0;
        end
    end

    // Requests are registered from the flags, one cycle behind them.
    // This gives the controller a clean flop output.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmpIrq_r <= 1'b0;
            ovfIrq_r <= 1'b0;
        end else begin
            cmpIrq_r <= cmpFlag_r && compareIrqEnable;
            ovfIrq_r <= ovfFlag_r && overflowIrqEnable;
        end
    end

    // ********************************************************************
    // Waveform generator
    // ********************************************************************
    // Action bits are read live each cycle, so a change acts at once.
    // Force wins a tie with a match; both act alike.
    always_comb begin
        outState_nxt = outState_r;
        if (!pwmMode) begin
            if (forceCompareStrobe) begin
                outState_nxt = apply_action(ctrl.outAction, outState_r);
            end else if (timerTick && liveMatch) begin
                outState_nxt = apply_action(ctrl.outAction, outState_r);
            end
        end else if (timerTick && ctrl.outAction[1]) begin
            // Action bit 0 selects the inverting form of the waveform.
            if (ctrl.waveMode == WGM_FASTPWM) begin
                if (isMax) begin
                    outState_nxt = ~ctrl.outAction[0];
                end else if (liveMatch) begin
                    outState_nxt = ctrl.outAction[0];
                end
            end else if (liveMatch) begin
                outState_nxt = (dir_r == DIR_UP) ? ctrl.outAction[0]
                                                 : ~ctrl.outAction[0];
            end
        end
    end

    // Reset is the only thing that reinitialises the output state.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            outState_r <= 1'b0;
        end else if (ctrl.outAction != ACT_NONE) begin
            outState_r <= outState_nxt;
        end
    end

    // Pin mux select; pin direction is kept outside.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            override_r <= 1'b0;
        end else begin
            override_r <= (ctrl.outAction != ACT_NONE);
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    // Every port is driven straight from a register.
    assign countValue    = count_r;
    assign compareValue  = cmpView_r;
    assign compareFlag   = cmpFlag_r;
    assign overflowFlag  = ovfFlag_r;
    assign compareIrq    = cmpIrq_r;
    assign overflowIrq   = ovfIrq_r;
    assign compareOutput = outState_r;
    assign portOverride  = override_r;

endmodule

// ---- design/tmr8_pkg.sv ----
/*
 * Package for the 8-bit timer with one compare channel: mode and action
 * encodings, clock select codes, prescaler taps and reset values.
 * Assumes nothing of its surroundings; every design file imports it whole.
 */
package tmr8_pkg;

    // ********************************************************************
    // Counter and mode encodings
    // ********************************************************************
    localparam int         CNT_W       = 8;
    localparam logic [7:0] CNT_BOTTOM  = 8'h00;
    localparam logic [7:0] CNT_MAX     = 8'hFF;
    localparam logic [7:0] CNT_RESET   = 8'h00;
    localparam logic [7:0] CMP_RESET   = 8'h00;

    localparam logic [1:0] WGM_NORMAL  = 2'h0;
    localparam logic [1:0] WGM_PCPWM   = 2'h1;
    localparam logic [1:0] WGM_CTC     = 2'h2;
    localparam logic [1:0] WGM_FASTPWM = 2'h3;

    localparam logic [1:0] ACT_NONE    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE  = 2'h1;
    localparam logic [1:0] ACT_CLEAR   = 2'h2;
    localparam logic [1:0] ACT_SET     = 2'h3;

    // ********************************************************************
    // Clock select codes and prescaler taps
    // ********************************************************************
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV32    = 3'h3;
    localparam logic [2:0] CS_DIV64    = 3'h4;
    localparam logic [2:0] CS_DIV128   = 3'h5;
    localparam logic [2:0] CS_DIV256   = 3'h6;
    localparam logic [2:0] CS_DIV1024  = 3'h7;
    localparam int         PRE_W       = 10;
    localparam logic [9:0] PRE_RESET   = 10'h000;

    // Control fields that travel together from the processor side.
    typedef struct packed {
        logic [1:0] waveMode;
        logic [1:0] outAction;
        logic [2:0] clockSel;
        logic       asyncSel;
    } tmr8_ctrl_s;

endpackage

// ---- design/tmr8_tick_gen.sv ----
/*
 * Timer tick generator: picks the I/O clock or the crystal input as the
 * source, divides it through a ten-bit prescaler and emits a one-cycle
 * tick at the selected rate.
 * Assumes the crystal input has already been brought into sys_clk; it is
 * treated as a synchronous level and one source pulse is made per rising edge.
 */
`timescale 1ns/1ps
module tmr8_tick_gen
    import tmr8_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Source selection
    input  wire logic       asyncClockSelect,
    input  wire logic       crystalPinIn,
    input  wire logic [2:0] clockSelectField,
    // Tick out
    output logic            timerTick
);

    logic [9:0] preCount_r;
    logic [9:0] preCount_nxt;
    logic       xtalPrev_r;
    logic       srcEdge;
    logic       tapHit;

    // ********************************************************************
    // Source edge
    // ********************************************************************
    // The crystal source counts rising edges; the I/O clock counts every
    // cycle, so the source pulse is one cycle wide either way.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            xtalPrev_r <= 1'b0;
        end else begin
            xtalPrev_r <= crystalPinIn;
        end
    end

    assign srcEdge = asyncClockSelect ? (crystalPinIn & ~xtalPrev_r) : 1'b1;

    // ********************************************************************
    // Prescaler
    // ********************************************************************
    // Free-running; a tap fires when all bits below it are ones, just before they wrap.
    assign preCount_nxt = preCount_r + 10'h001;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            preCount_r <= PRE_RESET;
        end else if (srcEdge) begin
            preCount_r <= preCount_nxt;
        end
    end

    always_comb begin
        case (clockSelectField)
            CS_STOP:    tapHit = 1'b0;
            CS_DIV1:    tapHit = 1'b1;
            CS_DIV8:    tapHit = (preCount_r[2:0] == 3'h7);
            CS_DIV32:   tapHit = (preCount_r[4:0] == 5'h1F);
            CS_DIV64:   tapHit = (preCount_r[5:0] == 6'h3F);
            CS_DIV128:  tapHit = (preCount_r[6:0] == 7'h7F);
            CS_DIV256:  tapHit = (preCount_r[7:0] == 8'hFF);
            CS_DIV1024: tapHit = (preCount_r == 10'h3FF);
            default:    tapHit = 1'b0;
        endcase
    end

    assign timerTick = srcEdge & tapHit;

endmodule

// ---- verification/tmr8_cc_monitor.sv ----
/*
 * Port-level checker for the 8-bit timer with one compare channel.
 * Assumes it is bound to tmr8_counter_compare and sees only its ports.
 */
`timescale 1ns/1ps
module tmr8_cc_monitor
    import tmr8_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset,
    // Design inputs
    input wire tmr8_ctrl_s ctrl,
    input wire logic       compareIrqEnable,
    input wire logic       overflowIrqEnable,
    input wire logic       countWrite,
    input wire logic [7:0] countWriteData,
    input wire logic       forceCompareStrobe,
    input wire logic       compareFlagClear,
    input wire logic       compareIrqAck,
    // Design outputs
    input wire logic [7:0] countValue,
    input wire logic [7:0] compareValue,
    input wire logic       compareFlag,
    input wire logic       overflowFlag,
    input wire logic       compareIrq,
    input wire logic       overflowIrq,
    input wire logic       compareOutput,
    input wire logic       portOverride
);
    // ****************
    // Helpers
    // ****************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Force only acts in the two modes without double buffering.
    logic nonPwm;
    assign nonPwm = (ctrl.waveMode == WGM_NORMAL)
                 || (ctrl.waveMode == WGM_CTC);

    // ****************
    // Properties
    // ****************
    property p_cmp_irq;
        compareIrq == $past(compareFlag & compareIrqEnable);
    endproperty
    a_cmp_irq: assert property (p_cmp_irq) else $error("cmp irq");
    property p_ovf_irq;
        overflowIrq == $past(overflowFlag & overflowIrqEnable);
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("ovf irq");
    property p_override;
        portOverride == $past(ctrl.outAction != ACT_NONE);
    endproperty
    a_override: assert property (p_override) else $error("ovr");
    // Two stopped cycles so no tick can still be in flight.
    property p_stop;
        (ctrl.clockSel == CS_STOP && !countWrite) [*2]
            |=> $stable(countValue);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved");
    property p_write;
        countWrite |=> countValue == $past(countWriteData);
    endproperty
    a_write: assert property (p_write) else $error("count wr");
    property p_act_none;
        ctrl.outAction == ACT_NONE |=> $stable(compareOutput);
    endproperty
    a_act_none: assert property (p_act_none) else $error("out");
    property p_force_set;
        forceCompareStrobe && nonPwm && ctrl.outAction == ACT_SET
            |=> compareOutput;
    endproperty
    a_force_set: assert property (p_force_set) else $error("set");
    property p_force_tog;
        forceCompareStrobe && nonPwm && ctrl.outAction == ACT_TOGGLE
            && ctrl.clockSel == CS_STOP && $past(ctrl.clockSel) == CS_STOP
            |=> compareOutput != $past(compareOutput);
    endproperty
    a_force_tog: assert property (p_force_tog) else $error("tog");
    property p_clr;
        (compareFlagClear || compareIrqAck) && ctrl.clockSel == CS_STOP
            && $past(ctrl.clockSel) == CS_STOP |=> !compareFlag;
    endproperty
    a_clr: assert property (p_clr) else $error("flag clear");
    property p_ovf_norm;
        $past(ctrl.waveMode) == WGM_NORMAL && !$past(countWrite)
            && $past(countValue) == CNT_MAX && countValue == CNT_BOTTOM
            |-> overflowFlag;
    endproperty
    a_ovf_norm: assert property (p_ovf_norm) else $error("ovf");
    property p_ctc;
        $past(ctrl.waveMode) == WGM_CTC && !$past(countWrite)
            && $past(countValue) == $past(compareValue)
            && $changed(countValue) |-> countValue == CNT_BOTTOM;
    endproperty
    a_ctc: assert property (p_ctc) else $error("ctc clear");

    // Main scenarios reached.
    c_match: cover property (compareFlag && !$past(compareFlag));
    c_ovf: cover property (overflowFlag && !$past(overflowFlag));
    c_force: cover property (forceCompareStrobe && nonPwm);
endmodule

bind tmr8_counter_compare tmr8_cc_monitor u_mon (
    .sys_clk, .reset, .ctrl, .compareIrqEnable, .overflowIrqEnable,
    .countWrite, .countWriteData, .forceCompareStrobe, .compareFlagClear,
    .compareIrqAck, .countValue, .compareValue, .compareFlag,
    .overflowFlag, .compareIrq, .overflowIrq, .compareOutput,
    .portOverride
);

// ---- verification/tmr8_counter_compare_test.sv ----
/*
 * Self-checking bench for the 8-bit timer with one compare channel.
 * Assumes the tick divider gives one tick a cycle at clock select one.
 */
`timescale 1ns/1ps
module tmr8_counter_compare_test
    import tmr8_pkg::*;
    ;
    // ****************
    // Stimulus and observed signals
    // ****************
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    tmr8_ctrl_s ctrl = '0;
    logic       compareIrqEnable = 1'b0;
    logic       overflowIrqEnable = 1'b0;
    logic       crystalPinIn = 1'b0;
    logic       countWrite = 1'b0;
    logic [7:0] countWriteData = 8'h00;
    logic       compareWrite = 1'b0;
    logic [7:0] compareWriteData = 8'h00;
    logic       forceCompareStrobe = 1'b0;
    logic       compareFlagClear = 1'b0;
    logic       overflowFlagClear = 1'b0;
    logic       compareIrqAck = 1'b0;
    logic       overflowIrqAck = 1'b0;
    logic [7:0] countValue;
    logic [7:0] compareValue;
    logic       compareFlag;
    logic       overflowFlag;
    logic       compareIrq;
    logic       overflowIrq;
    logic       compareOutput;
    logic       portOverride;
    int         mismatches = 0;
    int         n_compared = 0;
    int         divs[6] = '{8, 32, 64, 128, 256, 1024};

    always #4 sys_clk = ~sys_clk;

    tmr8_counter_compare dut (
        .sys_clk, .reset, .ctrl, .compareIrqEnable, .overflowIrqEnable,
        .crystalPinIn, .countWrite, .countWriteData, .compareWrite,
        .compareWriteData, .forceCompareStrobe, .compareFlagClear,
        .overflowFlagClear, .compareIrqAck, .overflowIrqAck,
        .countValue, .compareValue, .compareFlag, .overflowFlag,
        .compareIrq, .overflowIrq, .compareOutput, .portOverride
    );

    // ****************
    // Access tasks, all entered and left at a falling edge
    // ****************
    task automatic print_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One-cycle strobe; the caller lets an edge pass before reusing it.
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask

    task automatic wr_count(input logic [7:0] d);
        countWriteData = d;
        pulse(countWrite);
    endtask

    task automatic wr_cmp(input logic [7:0] d);
        compareWriteData = d;
        pulse(compareWrite);
    endtask

    // Bounded wait for a count value; running out ends the run.
    task automatic wait_cnt(input logic [7:0] v);
        for (int i = 0; i < 600 && countValue !== v; i++) cyc(1);
        if (countValue !== v) begin
            chk("countWait", v, countValue);
            print_verdict();
        end
    endtask

    task automatic run(input logic go);
        ctrl.clockSel = go ? CS_DIV1 : CS_STOP;
        if (!go) cyc(2);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        cyc(5);
        reset = 1'b0;
        cyc(1);
        chk("countValue", CNT_RESET, countValue);
        chk("compareValue", CMP_RESET, compareValue);
        chk("compareOutput", 8'h00, 8'(compareOutput));
        // Stopped counter keeps a written value; the write blocks a match.
        wr_count(8'h05);
        cyc(3);
        chk("countValue", 8'h05, countValue);
        wr_cmp(8'h05);
        chk("compareValue", 8'h05, compareValue);
        run(1'b1);
        wait_cnt(8'h07);
        chk("compareFlag", 8'h00, 8'(compareFlag));
        run(1'b0);
        // Match sets the flag one tick later; ack then software clear.
        ctrl.outAction = ACT_TOGGLE;
        compareIrqEnable = 1'b1;
        wr_cmp(8'h03);
        for (int k = 0; k < 2; k++) begin
            wr_count(8'h02);
            run(1'b1);
            wait_cnt(8'h04);
            chk("compareFlag", 8'h01, 8'(compareFlag));
            chk("compareOutput", 8'(k == 0), 8'(compareOutput));
            cyc(1);
            chk("compareIrq", 8'h01, 8'(compareIrq));
            run(1'b0);
            if (k == 0) pulse(compareIrqAck);
            else pulse(compareFlagClear);
            chk("compareFlag", 8'h00, 8'(compareFlag));
        end
        // Normal mode wrap sets overflow.
        overflowIrqEnable = 1'b1;
        wr_count(8'hFD);
        run(1'b1);
        wait_cnt(CNT_BOTTOM);
        chk("overflowFlag", 8'h01, 8'(overflowFlag));
        cyc(1);
        chk("overflowIrq", 8'h01, 8'(overflowIrq));
        run(1'b0);
        pulse(overflowIrqAck);
        chk("overflowFlag", 8'h00, 8'(overflowFlag));
        // Clear-on-match, then a running write beats the increment.
        ctrl.waveMode = WGM_CTC;
        wr_cmp(8'h04);
        wr_count(8'h00);
        run(1'b1);
        wait_cnt(8'h04);
        cyc(1);
        chk("countValue", 8'h00, countValue);
        wr_count(8'h40);
        chk("countValue", 8'h40, countValue);
        run(1'b0);
        // Forced matches: set, clear, toggle, none.
        pulse(compareFlagClear);
        ctrl.waveMode = WGM_NORMAL;
        for (int i = 0; i < 4; i++) begin
            ctrl.outAction = 2'(3 - i);
            pulse(forceCompareStrobe);
            chk("compareOutput", 8'(i != 1), 8'(compareOutput));
            chk("compareFlag", 8'h00, 8'(compareFlag));
            chk("portOverride", 8'(i != 3), 8'(portOverride));
            cyc(1);
        end
        ctrl.outAction = ACT_TOGGLE;
        ctrl.waveMode = WGM_FASTPWM;
        pulse(forceCompareStrobe);
        chk("compareOutput", 8'h01, 8'(compareOutput));
        // Buffered compare loads only at the top of the sequence.
        ctrl.outAction = ACT_CLEAR;
        wr_count(8'h10);
        wr_cmp(8'h80);
        chk("compareValue", 8'h80, compareValue);
        run(1'b1);
        wait_cnt(8'h90);
        chk("compareFlag", 8'h00, 8'(compareFlag));
        wait_cnt(CNT_BOTTOM);
        chk("overflowFlag", 8'h01, 8'(overflowFlag));
        wait_cnt(8'h81);
        chk("compareFlag", 8'h01, 8'(compareFlag));
        chk("compareOutput", 8'h00, 8'(compareOutput));
        wait_cnt(CNT_BOTTOM);
        chk("compareOutput", 8'h01, 8'(compareOutput));
        run(1'b0);
        pulse(overflowFlagClear);
        chk("overflowFlag", 8'h00, 8'(overflowFlag));
        // Phase correct turns round at max.
        ctrl.waveMode = WGM_PCPWM;
        wr_count(8'hFD);
        run(1'b1);
        wait_cnt(CNT_MAX);
        cyc(2);
        chk("countValue", 8'hFD, countValue);
        run(1'b0);
        // Crystal source: one tick per rising edge of the pin.
        ctrl.waveMode = WGM_NORMAL;
        ctrl.asyncSel = 1'b1;
        wr_count(8'h20);
        run(1'b1);
        cyc(4);
        chk("countValue", 8'h20, countValue);
        repeat (3) begin
            crystalPinIn = 1'b1;
            cyc(2);
            crystalPinIn = 1'b0;
            cyc(2);
        end
        cyc(3);
        chk("countValue", 8'h23, countValue);
        // Prescaler taps: two ticks in two periods of each tap.
        ctrl.asyncSel = 1'b0;
        foreach (divs[i]) begin
            wr_count(8'h00);
            ctrl.clockSel = 3'(i + 2);
            cyc(2 * divs[i]);
            ctrl.clockSel = CS_STOP;
            chk("prescaledCount", 8'h02, countValue);
        end
        print_verdict();
    end
endmodule
